// ===== rtl/rqds_status_bank.sv
// reference qualification, mask and loop status register bank
`timescale 1ns/1ps
`default_nettype none
`include "rqds_defines.svh"
module rqds_status_bank
  import rqds_pkg::*;
#(
  parameter int NUM_REFS = 8,
  parameter longint QUAL_CYCLES = longint'(`RQDS_QUAL_SECONDS) * `RQDS_CLK_HZ,
  parameter longint MINUTE_CYCLES = longint'(`RQDS_SECONDS_PER_MINUTE) * `RQDS_CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire rqds_host_req_t host_req,
  output logic [7:0] host_rdata,
  input wire logic [NUM_REFS-1:0] ref_activity,
  input wire logic [NUM_REFS-1:0] ref_pullin_ok,
  input wire logic manual_select,
  input wire logic [NUM_REFS-1:0] ref_returned,
  input wire rqds_loop_t loop_in,
  output logic [NUM_REFS-1:0] ref_usable,
  output logic [NUM_REFS-1:0] ref_revert_ready,
  output logic [7:0] phase_shift_q,
  output logic [7:0] osc_trim_q,
  output logic [3:0] pulse_width_q,
  output logic [1:0] sync_pulsed_q,
  output logic loss_of_lock_flag
);
  initial begin
    if (NUM_REFS != 8) $error("rqds_status_bank supports exactly eight references");
    if (QUAL_CYCLES < 2 || MINUTE_CYCLES < 1) $error("rqds_status_bank counts too small");
  end

  localparam int QW = $clog2(QUAL_CYCLES + 1);
  localparam int MW = $clog2(MINUTE_CYCLES + 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  logic [7:0] mask_ff;
  logic [7:0] rev_delay_ff;
  logic [7:0] phase_ff;
  logic [7:0] trim_ff;
  logic [3:0] pw_ff;
  logic [1:0] pulsed_ff;
  logic [7:0] qual_ff;
  logic [7:0] loop_ff;
  logic [QW-1:0] qual_cnt_ff [NUM_REFS];
  logic [MW-1:0] minute_cnt_ff;
  logic [7:0] rev_min_ff [NUM_REFS];
  logic [NUM_REFS-1:0] rev_run_ff;
  logic [7:0] rdata_ff;

  wire logic wr_mask = host_req.wr && hit(host_req.addr, `RQDS_ADDR_MASK);
  wire logic wr_rev = host_req.wr && hit(host_req.addr, `RQDS_ADDR_REV_DELAY);
  wire logic wr_phase = host_req.wr && hit(host_req.addr, `RQDS_ADDR_PHASE);
  wire logic wr_trim = host_req.wr && hit(host_req.addr, `RQDS_ADDR_TRIM);
  wire logic wr_pw = host_req.wr && hit(host_req.addr, `RQDS_ADDR_PULSE_WIDTH);
  // zero width would give no pulse at all, so it is folded to one
  wire logic [3:0] nxt_pw = (host_req.wdata[3:0] == `RQDS_PW_ZERO) ?
                            `RQDS_RST_PULSE_WIDTH : host_req.wdata[3:0];
  wire logic [7:0] ref_good = ref_activity & ref_pullin_ok;
  wire logic [7:0] avail = qual_ff & mask_ff;
  wire logic minute_tick = (minute_cnt_ff == MW'(MINUTE_CYCLES - 1));
  wire logic [7:0] nxt_loop = {3'b000, loop_in.history_built, loop_in.history_present,
                               loop_in.locked, loop_in.loss_of_lock,
                               loop_in.loss_of_signal};

  // masks only steer automatic selection; stored value survives manual mode
  assign ref_usable = manual_select ? 8'hff : avail;
  assign phase_shift_q = phase_ff;
  assign osc_trim_q = trim_ff;
  assign pulse_width_q = pw_ff;
  assign sync_pulsed_q = pulsed_ff;
  assign loss_of_lock_flag = loop_ff[`RQDS_LOOP_LOL_BIT];
  assign host_rdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= `RQDS_RST_MASK;
      rev_delay_ff <= `RQDS_RST_REV_DELAY;
      phase_ff <= `RQDS_RST_PHASE;
      trim_ff <= `RQDS_RST_TRIM;
      pw_ff <= `RQDS_RST_PULSE_WIDTH;
    end else begin
      // read-only addresses have no write path here
      if (wr_mask) mask_ff <= host_req.wdata;
      if (wr_rev) rev_delay_ff <= host_req.wdata;
      if (wr_phase) phase_ff <= host_req.wdata;
      if (wr_trim) trim_ff <= host_req.wdata;
      if (wr_pw) pw_ff <= nxt_pw;
    end
  end

  // pulse mode bits live in the mode register elsewhere; mirror held low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) pulsed_ff <= 2'b00;
    else pulsed_ff <= pulsed_ff;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_ff <= 8'h00;
      minute_cnt_ff <= '0;
    end else begin
      loop_ff <= nxt_loop;
      minute_cnt_ff <= minute_tick ? '0 : minute_cnt_ff + MW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REFS; gi++) begin : g_ref
      wire logic qual_done = (qual_cnt_ff[gi] == QW'(QUAL_CYCLES));
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          qual_cnt_ff[gi] <= '0;
          qual_ff[gi] <= 1'b0;
        end else if (!ref_good[gi]) begin
          qual_cnt_ff[gi] <= '0;
          qual_ff[gi] <= 1'b0;
        end else begin
          // count saturates at the limit and the flag is registered one cycle later, so presence is strictly longer
          if (!qual_done) qual_cnt_ff[gi] <= qual_cnt_ff[gi] + QW'(1);
          qual_ff[gi] <= qual_done;
        end
      end
      // reversion hold-off in whole minutes; a return restarts the wait, a drop cancels it
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          rev_min_ff[gi] <= 8'h00;
          rev_run_ff[gi] <= 1'b0;
        end else if (!avail[gi]) begin
          rev_min_ff[gi] <= 8'h00;
          rev_run_ff[gi] <= 1'b0;
        end else if (ref_returned[gi]) begin
          rev_min_ff[gi] <= 8'h00;
          rev_run_ff[gi] <= 1'b1;
        end else if (rev_run_ff[gi] && minute_tick && rev_min_ff[gi] != rev_delay_ff) begin
          rev_min_ff[gi] <= rev_min_ff[gi] + 8'h01;
        end
      end
      assign ref_revert_ready[gi] = avail[gi] &&
                                    (!rev_run_ff[gi] || rev_min_ff[gi] == rev_delay_ff);
    end
  endgenerate

  wire logic [7:0] rd_mux =
    hit(host_req.addr, `RQDS_ADDR_QUALIFIED) ? qual_ff :
    hit(host_req.addr, `RQDS_ADDR_MASK) ? mask_ff :
    hit(host_req.addr, `RQDS_ADDR_AVAILABLE) ? avail :
    hit(host_req.addr, `RQDS_ADDR_REV_DELAY) ? rev_delay_ff :
    hit(host_req.addr, `RQDS_ADDR_PHASE) ? phase_ff :
    hit(host_req.addr, `RQDS_ADDR_TRIM) ? trim_ff :
    hit(host_req.addr, `RQDS_ADDR_PULSE_WIDTH) ? {4'h0, pw_ff} :
    hit(host_req.addr, `RQDS_ADDR_LOOP_STATUS) ? loop_ff : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rdata_ff <= 8'h00;
    else if (host_req.rd) rdata_ff <= rd_mux;
  end

  a_pw_never_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pw_ff != `RQDS_PW_ZERO) else $error("pulse width zero");
  a_pw_zero_fold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_pw && host_req.wdata[3:0] == `RQDS_PW_ZERO |=> pw_ff == `RQDS_RST_PULSE_WIDTH)
    else $error("zero width not folded");
  a_avail_and: assert property (@(posedge ref_clk) disable iff (!reset_n)
    avail == (qual_ff & mask_ff)) else $error("available mismatch");
  a_qual_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ref_good[0] |=> !qual_ff[0]) else $error("qualified held without signal");
  a_qual_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(qual_ff[0]) |-> $past(ref_good[0], 2)) else $error("qualified too early");
  a_ro_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    host_req.wr && hit(host_req.addr, `RQDS_ADDR_QUALIFIED) && ref_good == $past(ref_good)
    |=> $stable(mask_ff)) else $error("read-only write disturbed mask");
  a_manual_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
    manual_select |-> ref_usable == 8'hff) else $error("mask applied in manual");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_mask |=> mask_ff == $past(host_req.wdata)) else $error("mask not stored");
  a_lol_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    loop_in.loss_of_lock |=> loss_of_lock_flag) else $error("loss of lock missed");
  a_locked_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !loop_in.locked |=> !loop_ff[`RQDS_LOOP_LOCKED_BIT]) else $error("locked held after loss");
  a_loop_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> loop_ff == $past(nxt_loop)) else $error("loop status not sampled");
  a_qual_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ref_good[0] && qual_ff[0] |=> qual_ff[0]) else $error("qualified dropped with signal");
  a_rev_pending: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rev_run_ff[0] && rev_min_ff[0] != rev_delay_ff |-> !ref_revert_ready[0])
    else $error("reversion ready before delay");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !host_req.rd |=> $stable(rdata_ff)) else $error("read data moved without read");
  a_rev_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ref_returned[0] && avail[0] && rev_delay_ff != 8'h00 |=> !ref_revert_ready[0])
    else $error("reversion without delay");
endmodule : rqds_status_bank
`default_nettype wire

// ===== rtl/rqds_defines.svh
// register map, field positions, reset values and timing counts for the reference status bank
`ifndef RQDS_DEFINES_SVH
`define RQDS_DEFINES_SVH
`define RQDS_ADDR_QUALIFIED 8'h0a
`define RQDS_ADDR_MASK 8'h0b
`define RQDS_ADDR_AVAILABLE 8'h0c
`define RQDS_ADDR_REV_DELAY 8'h0d
`define RQDS_ADDR_PHASE 8'h0e
`define RQDS_ADDR_TRIM 8'h0f
`define RQDS_ADDR_PULSE_WIDTH 8'h10
`define RQDS_ADDR_LOOP_STATUS 8'h11
`define RQDS_RST_MASK 8'h00
`define RQDS_RST_REV_DELAY 8'h05
`define RQDS_RST_PHASE 8'h00
`define RQDS_RST_TRIM 8'h00
`define RQDS_RST_PULSE_WIDTH 4'h1
`define RQDS_PW_ZERO 4'h0
`define RQDS_LOOP_LOL_BIT 1
`define RQDS_LOOP_LOCKED_BIT 2
`define RQDS_QUAL_SECONDS 10
`define RQDS_CLK_HZ 100_000_000
`define RQDS_SECONDS_PER_MINUTE 60
`endif

// ===== rtl/rqds_pkg.sv
// types shared by the reference status bank
package rqds_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rqds_host_req_t;
  typedef struct packed {
    logic loss_of_signal;
    logic loss_of_lock;
    logic locked;
    logic history_present;
    logic history_built;
  } rqds_loop_t;
  typedef enum logic {rqds_sel_auto, rqds_sel_manual} rqds_sel_t;
endpackage : rqds_pkg

// ===== verification/tb_top.sv
// self-checking bench for the reference status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rqds_pkg::*;
  logic ref_clk, reset_n, manual_select, loss_of_lock_flag;
  rqds_host_req_t host_req;
  rqds_loop_t loop_in;
  logic [7:0] host_rdata, ref_activity, ref_pullin_ok, ref_returned, ref_usable;
  logic [7:0] ref_revert_ready, phase_shift_q, osc_trim_q, v;
  logic [3:0] pulse_width_q;
  logic [1:0] sync_pulsed_q;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  // short counts keep qualification and reversion within a few dozen cycles
  rqds_status_bank #(.QUAL_CYCLES(20), .MINUTE_CYCLES(5)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .ref_activity(ref_activity), .ref_pullin_ok(ref_pullin_ok),
    .manual_select(manual_select), .ref_returned(ref_returned), .loop_in(loop_in),
    .ref_usable(ref_usable), .ref_revert_ready(ref_revert_ready),
    .phase_shift_q(phase_shift_q), .osc_trim_q(osc_trim_q), .pulse_width_q(pulse_width_q),
    .sync_pulsed_q(sync_pulsed_q), .loss_of_lock_flag(loss_of_lock_flag));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    host_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    host_req.rd <= 1'b0;
    #1 v = host_rdata;
  endtask : rd
  task automatic t_reset;
    rd(8'h0b); chk("mask", v, 8'h00);
    rd(8'h0d); chk("rev_delay", v, 8'h05);
    rd(8'h10); chk("width", v, 8'h01);
    rd(8'h0a); chk("qualified", v, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fields;
    wr(8'h0e, 8'h80); wr(8'h0f, 8'hff); wr(8'h10, 8'h00);
    chk("phase_q", phase_shift_q, 8'h80);
    chk("trim_q", osc_trim_q, 8'hff);
    rd(8'h10); chk("width_zero", v, 8'h01);
    chk("width_q", {4'h0, pulse_width_q}, 8'h01);
    chk("pulsed_q", {6'h00, sync_pulsed_q}, 8'h00);
    wr(8'h10, 8'h0f); rd(8'h10); chk("width_max", v, 8'h0f);
    rd(8'h0e); chk("phase", v, 8'h80);
    $display("field test done");
  endtask : t_fields
  task automatic t_qualify;
    @(posedge ref_clk);
    ref_activity <= 8'h0f;
    ref_pullin_ok <= 8'h07;
    repeat (15) @(posedge ref_clk);
    rd(8'h0a); chk("qual_early", v, 8'h00);
    repeat (8) @(posedge ref_clk);
    rd(8'h0a); chk("qual_set", v, 8'h07);
    wr(8'h0b, 8'h05); rd(8'h0c); chk("avail", v, 8'h05);
    chk("usable_auto", ref_usable, 8'h05);
    wr(8'h0c, 8'hff); wr(8'h0a, 8'h00); rd(8'h0c); chk("avail_ro", v, 8'h05);
    rd(8'h0a); chk("qual_ro", v, 8'h07);
    @(posedge ref_clk);
    manual_select <= 1'b1;
    @(posedge ref_clk);
    #1 chk("usable_man", ref_usable, 8'hff);
    rd(8'h0b); chk("mask_kept", v, 8'h05);
    manual_select <= 1'b0;
    @(posedge ref_clk);
    #1 chk("usable_back", ref_usable, 8'h05);
    wr(8'h0d, 8'h01);
    @(posedge ref_clk);
    ref_returned <= 8'h01;
    @(posedge ref_clk);
    ref_returned <= 8'h00;
    #1 chk("revert_wait", ref_revert_ready, 8'h04);
    repeat (12) @(posedge ref_clk);
    #1 chk("revert_ready", ref_revert_ready, 8'h05);
    ref_activity <= 8'h0e;
    repeat (3) @(posedge ref_clk);
    rd(8'h0a); chk("qual_drop", v, 8'h06);
    ref_pullin_ok <= 8'h03;
    repeat (3) @(posedge ref_clk);
    rd(8'h0a); chk("pullin_drop", v, 8'h02);
    $display("qualify test done");
  endtask : t_qualify
  task automatic t_loop;
    loop_in <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    rd(8'h11); rd(8'h11); chk("loop_a", v, 8'h0d);
    chk("lol_a", {7'h00, loss_of_lock_flag}, 8'h00);
    loop_in <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    rd(8'h11); rd(8'h11); chk("loop_b", v, 8'h12);
    chk("lol_b", {7'h00, loss_of_lock_flag}, 8'h01);
    wr(8'h11, 8'hff); rd(8'h11); chk("loop_ro", v, 8'h12);
    $display("loop test done");
  endtask : t_loop
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    reset_n = 1'b0;
    host_req = '0;
    loop_in = '0;
    manual_select = 1'b0;
    ref_activity = 8'h00;
    ref_pullin_ok = 8'h00;
    ref_returned = 8'h00;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_qualify();
    t_loop();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
